// >>> pkg/smbra_pkg.sv
// shared constants and types for the smbus ram/eeprom access slave
package smbra_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLOCK_HZ       = 50_000_000;
   localparam int unsigned CYC_PER_US     = CLOCK_HZ / 1_000_000;
   localparam int unsigned ERASE_TIME_US  = 20_000;
   localparam int unsigned ERASE_CYCLES   = ERASE_TIME_US * CYC_PER_US;
   localparam int unsigned PROG_TIME_US   = 250;
   localparam int unsigned PROG_CYCLES    = PROG_TIME_US * CYC_PER_US;

   // ==========================================================
   // addressing and command codes
   localparam logic [4:0] SLAVE_ADDR_UPPER = 5'h0F;
   localparam logic [7:0] RAM_LAST         = 8'hDF;
   localparam logic [7:0] EE_HI_FIRST      = 8'hF8;
   localparam logic [7:0] EE_HI_LAST       = 8'hFB;
   localparam logic [7:0] CMD_PAGE_ERASE   = 8'hFE;
   localparam logic [7:0] CFG_UPDATE_OFFSET = 8'h90;
   localparam int unsigned CFG_ERASE_EN_BIT = 2;
   localparam logic [7:0] CFG_UPDATE_RESET = 8'h00;
   localparam int unsigned EE_ADDR_W       = 10;
   localparam int unsigned EE_PAGE_LSB     = 5;
   localparam int unsigned BITS_PER_BYTE   = 8;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_RX     = 4'h2,
      ST_TX     = 4'h4,
      ST_IGNORE = 4'h8
   } smbra_state_type;

   typedef struct packed {
      logic                 erase;
      logic                 prog;
      logic [EE_ADDR_W-1:0] addr;
      logic [7:0]           data;
   } smbra_ee_req_type;

endpackage

// >>> verification/smbra_master_model.sv
// smbus master model pulling the open-drain bus lines
`timescale 1ns/100ps
module smbra_master_model (
   input  wire logic i_scl_line,
   input  wire logic i_sda_line,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   localparam int Q = 40;
   // ====
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // release scl, then wait while the slave stretches it
   task automatic rise();
      int n;
      o_scl_low = 1'b0;
      for (n = 0; n < 400 && !i_scl_line; n++) #Q;
   endtask
   task automatic bit_cyc(input logic v, output logic s);
      int n;
      #Q o_sda_low = ~v;
      for (n = 0; n < 8 && v && !i_sda_line; n++) #5;
      #(2*Q) rise();
      #(Q-5) s = i_sda_line;
      #5 o_scl_low = 1'b1;
   endtask
   task automatic start();
      #Q o_sda_low = 1'b0;
      rise();
      #Q o_sda_low = 1'b1;
      #Q o_scl_low = 1'b1;
   endtask
   task automatic stop();
      #Q o_sda_low = 1'b1;
      #Q rise();
      #Q o_sda_low = 1'b0;
      #(2*Q);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
      bit_cyc(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, s);
         d[i] = s;
      end
      bit_cyc(1'b1, s);
   endtask
endmodule

// >>> verification/smbra_slave_chk.sv
// port assertions for the smbus ram/eeprom access slave
`timescale 1ns/100ps
module smbra_slave_chk #(
   parameter int unsigned P_ERASE_CYCLES = 200
) (
   input wire logic                        i_clock,
   input wire logic                        i_srst,
   input wire logic                        i_config_loaded,
   input wire logic                        o_scl_oe,
   input wire logic                        o_sda_oe,
   input wire smbra_pkg::smbra_ee_req_type o_ee_req,
   input wire logic [7:0]                  o_config_update,
   input wire logic                        o_erase_busy,
   input wire logic                        o_prog_busy
);
   localparam int SETTLE = 40;
   logic [31:0] ecnt_q;
   logic [31:0] ecnt_d;
   // ====
   // length of the running erase busy stretch
   always_comb begin
      ecnt_d = (i_srst || !o_erase_busy) ? 32'h0 : ecnt_q + 32'h1;
   end
   always_ff @(posedge i_clock) begin
      ecnt_q <= ecnt_d;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // ====
   a_erase_needs_en: assert property (
      o_ee_req.erase |-> o_config_update[2]) else $error("erase while off");
   a_erase_page_align: assert property (
      o_ee_req.erase |-> o_ee_req.addr[4:0] == 5'h00)
      else $error("erase address not page aligned");
   a_erase_sets_busy: assert property (
      o_ee_req.erase |=> o_erase_busy) else $error("erase busy missing");
   a_erase_busy_len: assert property (
      $fell(o_erase_busy) |-> ecnt_q == P_ERASE_CYCLES)
      else $error("erase busy length wrong");
   a_prog_sets_busy: assert property (
      o_ee_req.prog |=> o_prog_busy) else $error("prog busy missing");
   a_no_ack_erasing: assert property (
      o_erase_busy && ecnt_q > SETTLE |-> !$rose(o_sda_oe))
      else $error("ack while erasing");
   a_no_ack_unloaded: assert property (
      !i_config_loaded |-> !o_sda_oe && !o_scl_oe)
      else $error("bus driven before download");
   a_stretch_ends: assert property (
      o_scl_oe && !o_prog_busy |=> !o_scl_oe)
      else $error("stretch held past programming");
   c_erase: cover property (o_ee_req.erase);
   c_stretch: cover property (o_scl_oe && o_prog_busy);
   c_ack: cover property ($rose(o_sda_oe));
endmodule
bind smbra_slave smbra_slave_chk #(.P_ERASE_CYCLES(P_ERASE_CYCLES))
   smbra_slave_chk_inst (
   .i_clock(i_clock), .i_srst(i_srst), .i_config_loaded(i_config_loaded),
   .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_ee_req(o_ee_req),
   .o_config_update(o_config_update), .o_erase_busy(o_erase_busy),
   .o_prog_busy(o_prog_busy));

// >>> verification/smbus_ram_eeprom_access_slave_tb.sv
// self-checking bench for the smbus ram/eeprom access slave
`timescale 1ns/100ps
module smbus_ram_eeprom_access_slave_tb;
   logic                        clock, srst, sel_hi, sel_lo, loaded, str;
   logic                        m_scl, m_sda, scl_out, scl_oe, sda_out;
   logic                        sda_oe, erase_busy, prog_busy;
   logic [7:0]                  cfg, rd, dw, a, p, v, c, ak, ram_m [0:255];
   logic [9:0]                  er_a, pr_a;
   logic [7:0]                  pr_d;
   int                          err_count, checks_done, er_n, pr_n, seed, n;
   smbra_pkg::smbra_ee_req_type ee_req;
   wire                         scl_line = ~(m_scl | scl_oe);
   wire                         sda_line = ~(m_sda | sda_oe);
   // ====
   smbra_slave #(.P_ERASE_CYCLES(200), .P_PROG_CYCLES(100)) smbra_slave_inst (
      .i_clock(clock), .i_srst(srst), .i_scl(scl_line), .i_sda(sda_line),
      .i_addr_select_hi_pin(sel_hi), .i_addr_select_lo_pin(sel_lo),
      .i_config_loaded(loaded), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_ee_req(ee_req),
      .o_config_update(cfg), .o_erase_busy(erase_busy),
      .o_prog_busy(prog_busy));
   smbra_master_model smbra_master_model_inst (.i_scl_line(scl_line),
      .i_sda_line(sda_line), .o_scl_low(m_scl), .o_sda_low(m_sda));
   always #10 clock = ~clock;
   // sampled mid-cycle so one-cycle request pulses count exactly once
   always @(negedge clock) begin
      if (ee_req.erase === 1'b1) begin
         er_n++;
         er_a = ee_req.addr;
      end
      if (ee_req.prog === 1'b1) begin
         pr_n++;
         pr_a = ee_req.addr;
         pr_d = ee_req.data;
      end
      if (scl_oe === 1'b1) str = 1'b1;
   end
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // whole write transaction; bit i of k is the ack of byte i
   task automatic send(input logic [7:0] q[$], output logic [7:0] k);
      logic b;
      k = 8'h00;
      smbra_master_model_inst.start();
      foreach (q[i]) begin
         smbra_master_model_inst.wbyte(q[i], b);
         k[i] = b;
      end
      smbra_master_model_inst.stop();
   endtask
   task automatic rdb(output logic [7:0] d);
      logic b;
      smbra_master_model_inst.start();
      smbra_master_model_inst.wbyte(dw | 8'h01, b);
      smbra_master_model_inst.rbyte(d);
      smbra_master_model_inst.stop();
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #1_500_000;
      err_count++;
      end_of_test();
   end
   // ====
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      loaded = 1'b0;
      {sel_hi, sel_lo, str} = 3'h0;
      {err_count, checks_done, er_n, pr_n} = '0;
      seed = 84;
      dw = 8'h78;
      p = 8'hDF;
      repeat (20) @(posedge clock);
      #2 srst = 1'b0;
      repeat (10) @(posedge clock);
      send('{dw}, ak);
      chk("ack_unloaded", ak, 0);
      for (n = 0; n < 4; n++) begin
         @(posedge clock);
         #2 {sel_hi, sel_lo, loaded} = {n[1:0], 1'b1};
         dw = {5'h0F, n[1:0], 1'b0};
         repeat (8) @(posedge clock);
         send('{dw ^ 8'h02, 8'h00}, ak);
         chk("ack_other", ak, 0);
         send('{dw}, ak);
         chk("ack_own", ak, 1);
      end
      for (n = 0; n < 4; n++) begin
         a = n == 0 ? 8'hDF : n == 1 ? 8'h00 : 8'($unsigned($random(seed)) % 224);
         v = 8'($random(seed));
         send('{dw, a, v}, ak);
         chk("ack_wbyte", ak, 7);
         ram_m[a] = v;
         send('{dw, p}, ak);
         chk("ack_sbyte", ak, 3);
         rdb(rd);
         chk("ram_read", rd, ram_m[p]);
         p = a;
      end
      send('{dw, 8'hE0, 8'h5A}, ak);
      chk("ack_e0", ak, 3);
      send('{dw, 8'h10, v, v}, ak);
      chk("ack_extra", ak, 7);
      c = 8'($random(seed)) & 8'hFB;
      send('{dw, 8'h90, c}, ak);
      chk("cfg", cfg, c);
      a = 8'($random(seed));
      send('{dw, 8'hF9, a}, ak);
      chk("ack_eptr", ak, 7);
      send('{dw, 8'hFE}, ak);
      chk("erase_off", er_n, 0);
      c = c | 8'h04;
      ram_m[8'h90] = c;
      send('{dw, 8'h90, c}, ak);
      send('{dw, 8'hFE}, ak);
      chk("erase_n", er_n, 1);
      chk("erase_addr", er_a, {2'b01, a[7:5], 5'h00});
      send('{dw}, ak);
      chk("ack_busy", ak, 0);
      for (n = 0; n < 1000 && erase_busy !== 1'b0; n++) @(posedge clock);
      chk("erase_done", n < 1000, 1);
      a = 8'($random(seed));
      v = 8'($random(seed));
      send('{dw, 8'hFA, a, v}, ak);
      chk("ack_word", ak, 15);
      chk("prog", {pr_n[3:0], pr_a, pr_d}, {4'h1, 2'b10, a, v});
      chk("stretch", str, 1);
      rdb(rd);
      chk("ptr_kept", rd, ram_m[8'h90]);
      chk("prog_idle", prog_busy, 1'b0);
      chk("pin_levels", {scl_out, sda_out}, 2'h0);
      end_of_test();
   end
endmodule

// >>> verilog/smbra_byte_ram.sv
// byte-wide ram with one write port and a registered read port
`timescale 1ns/100ps
module smbra_byte_ram #(
   parameter int unsigned DATA_W = 8,
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              i_clock,
   input  wire logic              i_wr_en,
   input  wire logic [ADDR_W-1:0] i_wr_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic [ADDR_W-1:0] i_rd_addr,
   output logic      [DATA_W-1:0] o_rd_data
);

   logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

   always_ff @(posedge i_clock) begin
      if (i_wr_en) begin
         mem_q[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem_q[i_rd_addr];
   end

endmodule

// >>> verilog/smbra_slave.sv
// smbus slave front end and ram/eeprom command decoder
//
// Contract
// - start is sda falling while scl high; begin shifting a new address byte.
// - first byte is seven-bit address msb first, then direction bit, 0 write.
// - on address match drive sda low through the ninth clock pulse.
// - on address mismatch stay idle with sda released until next start or stop.
// - nine pulses per byte: eight data plus acknowledge; sda changes with scl low.
// - first byte after address in a write is the command or register address.
// - ram decodes 0x00 to 0xDF, eeprom decodes 0xF800 to 0xFBFF.
// - eeprom bytes program only when blank; erase is whole 32-byte pages only.
// - page erase honoured only while bit 2 of config register 0x90 is set.
// - send byte: address and one command byte, both acknowledged, then stop.
// - send byte with ram address loads the pointer used by later reads.
// - send byte 0xFE erases the page of the last eeprom address set.
// - erase starts when the command byte arrives and lasts about 20 ms.
// - while erase runs the device acknowledges no access to it.
// - write byte/word: command then one or two data bytes, each acknowledged.
// - write byte with command 0x00 to 0xDF stores data in that ram register.
// - command 0xF8 to 0xFB with one data byte sets the eeprom pointer.
// - page erase uses only top three bits of the eeprom low address byte.
// - command 0xF8 to 0xFB with two data bytes programs one eeprom byte.
// - slave address is 01111 followed by the two address select pins.
// - no acknowledge until the power-up configuration download has completed.
// - while a byte programs, about 250 us, hold scl low when not ready.
`timescale 1ns/100ps
module smbra_slave #(
   parameter int unsigned P_ERASE_CYCLES = smbra_pkg::ERASE_CYCLES,
   parameter int unsigned P_PROG_CYCLES  = smbra_pkg::PROG_CYCLES
) (
   input  wire logic                        i_clock,
   input  wire logic                        i_srst,
   input  wire logic                        i_scl,
   input  wire logic                        i_sda,
   input  wire logic                        i_addr_select_hi_pin,
   input  wire logic                        i_addr_select_lo_pin,
   input  wire logic                        i_config_loaded,
   output logic                             o_scl_out,
   output logic                             o_scl_oe,
   output logic                             o_sda_out,
   output logic                             o_sda_oe,
   output smbra_pkg::smbra_ee_req_type      o_ee_req,
   output logic [7:0]                       o_config_update,
   output logic                             o_erase_busy,
   output logic                             o_prog_busy
);

   localparam int unsigned ECNT_W = $clog2(P_ERASE_CYCLES + 1);
   localparam int unsigned PCNT_W = $clog2(P_PROG_CYCLES + 1);

   function automatic logic is_ram(input logic [7:0] a);
      is_ram = (a <= smbra_pkg::RAM_LAST);
   endfunction

   function automatic logic is_ee_hi(input logic [7:0] a);
      is_ee_hi = (a >= smbra_pkg::EE_HI_FIRST) &&
                 (a <= smbra_pkg::EE_HI_LAST);
   endfunction

   // ==========================================================
   // pin synchronisers: bits are {sel_hi, sel_lo, sda, scl}
   logic [3:0] s1_q, s2_q, s3_q, filt_q, prev_q;
   logic [3:0] filt_d;
   logic       scl_rise, scl_fall, start_det, stop_det;

   always_comb begin
      filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         s1_q   <= 4'hF;
         s2_q   <= 4'hF;
         s3_q   <= 4'hF;
         filt_q <= 4'hF;
         prev_q <= 4'hF;
      end else begin
         s1_q   <= {i_addr_select_hi_pin, i_addr_select_lo_pin, i_sda, i_scl};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end

   assign scl_rise  = filt_q[0] & ~prev_q[0];
   assign scl_fall  = ~filt_q[0] & prev_q[0];
   assign start_det = filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1];
   assign stop_det  = filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1];

   // ==========================================================
   // busy timers for page erase and byte programming
   logic [ECNT_W-1:0] ecnt_q, ecnt_d;
   logic [PCNT_W-1:0] pcnt_q, pcnt_d;
   logic              erase_busy, prog_busy;
   smbra_pkg::smbra_ee_req_type req_q, req_d;

   assign erase_busy = (ecnt_q != '0);
   assign prog_busy  = (pcnt_q != '0);

   always_comb begin
      ecnt_d = ecnt_q;
      pcnt_d = pcnt_q;
      if (req_q.erase) begin
         ecnt_d = ECNT_W'(P_ERASE_CYCLES);
      end else if (erase_busy) begin
         ecnt_d = ecnt_q - 1'b1;
      end
      if (req_q.prog) begin
         pcnt_d = PCNT_W'(P_PROG_CYCLES);
      end else if (prog_busy) begin
         pcnt_d = pcnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ecnt_q <= '0;
         pcnt_q <= '0;
      end else begin
         ecnt_q <= ecnt_d;
         pcnt_q <= pcnt_d;
      end
   end

   // ==========================================================
   // byte framing and command decode
   localparam int unsigned EE_ADDR_W_T = smbra_pkg::EE_ADDR_W;

   smbra_pkg::smbra_state_type state_q, state_d;
   logic [3:0]  bitcnt_q, bitcnt_d;
   logic [1:0]  idx_q, idx_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  cmd_q, cmd_d;
   logic [7:0]  ram_ptr_q, ram_ptr_d;
   logic [EE_ADDR_W_T-1:0] ee_ptr_q, ee_ptr_d;
   logic [7:0]  cfg_q, cfg_d;
   logic [7:0]  tx_q, tx_d;
   logic        ack_q, ack_d, rw_q, rw_d;
   logic        sda_oe_q, sda_oe_d, stretch_q, stretch_d;
   logic        wr_en_q, wr_en_d;
   logic [7:0]  wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
   logic [7:0]  rx_byte, rd_data;
   logic [6:0]  own_addr;

   assign rx_byte  = {shift_q[6:0], filt_q[1]};
   assign own_addr = {smbra_pkg::SLAVE_ADDR_UPPER, filt_q[3:2]};

   always_comb begin
      state_d   = state_q;
      bitcnt_d  = bitcnt_q;
      idx_d     = idx_q;
      shift_d   = shift_q;
      cmd_d     = cmd_q;
      ram_ptr_d = ram_ptr_q;
      ee_ptr_d  = ee_ptr_q;
      cfg_d     = cfg_q;
      tx_d      = tx_q;
      ack_d     = ack_q;
      rw_d      = rw_q;
      sda_oe_d  = sda_oe_q;
      stretch_d = stretch_q & prog_busy;
      wr_en_d   = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      req_d       = req_q;
      req_d.erase = 1'b0;
      req_d.prog  = 1'b0;
      if (start_det) begin
         state_d  = smbra_pkg::ST_RX;
         bitcnt_d = 4'h0;
         idx_d    = 2'h0;
         ack_d    = 1'b0;
         rw_d     = 1'b0;
         sda_oe_d = 1'b0;
      end else if (stop_det) begin
         state_d   = smbra_pkg::ST_IDLE;
         sda_oe_d  = 1'b0;
         stretch_d = 1'b0;
      end else begin
         case (state_q)
            smbra_pkg::ST_RX,
            smbra_pkg::ST_TX: begin
               if (scl_rise && bitcnt_q < 4'h8) begin
                  shift_d  = rx_byte;
                  bitcnt_d = bitcnt_q + 4'h1;
                  if (bitcnt_q == 4'h7 && state_q == smbra_pkg::ST_RX) begin
                     ack_d = 1'b1;
                     case (idx_q)
                        2'h0: begin
                           if (rx_byte[7:1] != own_addr || erase_busy ||
                               !i_config_loaded) begin
                              ack_d   = 1'b0;
                              state_d = smbra_pkg::ST_IGNORE;
                           end
                           rw_d = rx_byte[0];
                        end
                        2'h1: begin
                           cmd_d = rx_byte;
                           if (is_ram(rx_byte)) begin
                              ram_ptr_d = rx_byte;
                           end
                           if (rx_byte == smbra_pkg::CMD_PAGE_ERASE &&
                               cfg_q[smbra_pkg::CFG_ERASE_EN_BIT]) begin
                              req_d.erase = 1'b1;
                              req_d.prog  = 1'b0;
                              req_d.addr  = {ee_ptr_q[EE_ADDR_W_T-1:
                                                      smbra_pkg::EE_PAGE_LSB],
                                             5'h00};
                           end
                        end
                        2'h2: begin
                           if (is_ram(cmd_q)) begin
                              wr_en_d   = 1'b1;
                              wr_addr_d = cmd_q;
                              wr_data_d = rx_byte;
                              if (cmd_q == smbra_pkg::CFG_UPDATE_OFFSET) begin
                                 cfg_d = rx_byte;
                              end
                           end else if (is_ee_hi(cmd_q)) begin
                              ee_ptr_d = {cmd_q[1:0], rx_byte};
                           end else begin
                              ack_d = 1'b0;
                           end
                        end
                        default: begin
                           if (is_ee_hi(cmd_q) && idx_q == 2'h3) begin
                              req_d.erase = 1'b0;
                              req_d.prog  = 1'b1;
                              req_d.addr  = ee_ptr_q;
                              req_d.data  = rx_byte;
                           end else begin
                              ack_d = 1'b0;
                           end
                        end
                     endcase
                  end
               end else if (scl_rise && bitcnt_q == 4'h8) begin
                  bitcnt_d = 4'h9;
                  if (state_q == smbra_pkg::ST_TX && filt_q[1]) begin
                     state_d = smbra_pkg::ST_IGNORE;
                  end
               end else if (scl_fall) begin
                  if (bitcnt_q == 4'h8) begin
                     sda_oe_d = (state_q == smbra_pkg::ST_RX) && ack_q;
                  end else if (bitcnt_q == 4'h9) begin
                     bitcnt_d = 4'h0;
                     ack_d    = 1'b0;
                     if (idx_q != 2'h3) begin
                        idx_d = idx_q + 2'h1;
                     end
                     if (rw_q) begin
                        state_d  = smbra_pkg::ST_TX;
                        tx_d     = rd_data;
                        sda_oe_d = ~rd_data[7];
                     end else begin
                        sda_oe_d  = 1'b0;
                        stretch_d = prog_busy;
                     end
                  end else if (state_q == smbra_pkg::ST_TX &&
                               bitcnt_q != 4'h0) begin
                     sda_oe_d = ~tx_q[3'(4'h7 - bitcnt_q)];
                  end
               end
            end
            smbra_pkg::ST_IGNORE: begin
               sda_oe_d = 1'b0;
            end
            smbra_pkg::ST_IDLE: begin
               sda_oe_d = 1'b0;
            end
            default: begin
               state_d  = smbra_pkg::ST_IDLE;
               sda_oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_q   <= smbra_pkg::ST_IDLE;
         bitcnt_q  <= 4'h0;
         idx_q     <= 2'h0;
         shift_q   <= 8'h00;
         cmd_q     <= 8'h00;
         ram_ptr_q <= 8'h00;
         ee_ptr_q  <= '0;
         cfg_q     <= smbra_pkg::CFG_UPDATE_RESET;
         tx_q      <= 8'h00;
         ack_q     <= 1'b0;
         rw_q      <= 1'b0;
         sda_oe_q  <= 1'b0;
         stretch_q <= 1'b0;
         wr_en_q   <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         req_q     <= '0;
      end else begin
         state_q   <= state_d;
         bitcnt_q  <= bitcnt_d;
         idx_q     <= idx_d;
         shift_q   <= shift_d;
         cmd_q     <= cmd_d;
         ram_ptr_q <= ram_ptr_d;
         ee_ptr_q  <= ee_ptr_d;
         cfg_q     <= cfg_d;
         tx_q      <= tx_d;
         ack_q     <= ack_d;
         rw_q      <= rw_d;
         sda_oe_q  <= sda_oe_d;
         stretch_q <= stretch_d;
         wr_en_q   <= wr_en_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         req_q     <= req_d;
      end
   end

   // ==========================================================
   // configuration ram
   smbra_byte_ram #(
      .DATA_W (8),
      .ADDR_W (8)
   ) u_ram (
      .i_clock   (i_clock),
      .i_wr_en   (wr_en_q),
      .i_wr_addr (wr_addr_q),
      .i_wr_data (wr_data_q),
      .i_rd_addr (ram_ptr_q),
      .o_rd_data (rd_data)
   );

   // ==========================================================
   // outputs
   assign o_scl_out       = 1'b0;
   assign o_scl_oe        = stretch_q;
   assign o_sda_out       = 1'b0;
   assign o_sda_oe        = sda_oe_q;
   assign o_ee_req        = req_q;
   assign o_config_update = cfg_q;
   assign o_erase_busy    = erase_busy;
   assign o_prog_busy     = prog_busy;

endmodule
